// ==== xaa_attr_decode.sv ====
// Top of the external address attribute decode and byte packing control.
// Assumes one external cycle at a time, finished by a one-cycle done from the bus.
// Assumes inputs are synchronous to the core clock.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module xaa_attr_decode (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [23:0] i_reg_addr,
  input wire logic [23:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [23:0] o_reg_rdata,
  // Access request from core or DMA
  input wire logic i_acc_req,
  input wire logic [23:0] i_acc_addr,
  input wire logic [1:0] i_acc_space,
  input wire logic i_acc_dma,
  input wire logic i_acc_wr,
  input wire logic [23:0] i_acc_wdata,
  input wire logic i_acc_internal,
  output logic o_acc_busy,
  output logic o_acc_done,
  output logic [23:0] o_acc_rdata,
  // External bus cycle control
  output logic o_ext_cyc,
  output logic o_ext_wr,
  output logic o_ext_byte_mode,
  output logic [23:0] o_ext_addr,
  output logic [23:0] o_ext_wdata,
  input wire logic [23:0] i_ext_rdata,
  input wire logic i_ext_done,
  output logic o_bus_hold,
  // Attribute strobe pins
  output logic [3:0] o_attr_strobe
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Register index decode: bit 2 says mapped, bits 1..0 give the index
  function automatic logic [2:0] sel_index(input logic [23:0] a);
    case (a)
      xaa_pkg::OFS_SEL0: sel_index = 3'h4;
      xaa_pkg::OFS_SEL1: sel_index = 3'h5;
      xaa_pkg::OFS_SEL2: sel_index = 3'h6;
      xaa_pkg::OFS_SEL3: sel_index = 3'h7;
      default: sel_index = 3'h0;
    endcase
  endfunction : sel_index

  // Byte of a word for one beat, low byte first
  function automatic logic [7:0] get_byte(input logic [23:0] w, input logic [1:0] b);
    case (b)
      2'h0: get_byte = w[7:0];
      2'h1: get_byte = w[15:8];
      default: get_byte = w[23:16];
    endcase
  endfunction : get_byte

  // Word with one beat's byte replaced
  function automatic logic [23:0] put_byte(input logic [23:0] w, input logic [1:0] b,
                                           input logic [7:0] v);
    case (b)
      2'h0: put_byte = {w[23:8], v};
      2'h1: put_byte = {w[23:16], v, w[7:0]};
      default: put_byte = {v, w[15:0]};
    endcase
  endfunction : put_byte

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [23:0] sel_r [4];        // Attribute select registers
  logic [23:0] reg_rdata_r;      // Read data, one cycle after the strobe
  wire logic [2:0] wr_idx_w;     // Decoded write target
  wire logic [2:0] rd_idx_w;     // Decoded read target
  wire logic [23:0] rd_val_w;    // Selected register, reserved bits cleared

  assign wr_idx_w = sel_index(i_reg_addr);
  assign rd_idx_w = sel_index(i_reg_addr);
  // Unmapped reads answer zero
  assign rd_val_w = rd_idx_w[2] ? (sel_r[rd_idx_w[1:0]] & xaa_pkg::SEL_RW_MASK)
                                : 24'h000000;

  // Writes land whole; reserved bits are never stored so they read zero
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        sel_r[i] <= xaa_pkg::SEL_RESET;
      end
    end else if (i_reg_wr && wr_idx_w[2]) begin
      sel_r[wr_idx_w[1:0]] <= i_reg_wdata & xaa_pkg::SEL_RW_MASK;
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reg_rdata_r <= 24'h000000;
    end else begin
      reg_rdata_r <= i_reg_rd ? rd_val_w : 24'h000000;
    end
  end

  assign o_reg_rdata = reg_rdata_r;

  // ---------------------------------------------------------------------------
  // Access sequencer state
  // ---------------------------------------------------------------------------
  xaa_pkg::xaa_state_t state_r;       // Sequencer state
  xaa_pkg::xaa_state_t state_nxt;
  logic [23:0] base_r;                // Address taken with the request
  xaa_pkg::xaa_space_t space_r;       // Space taken with the request
  logic internal_r;                   // Internal-map flag of the request
  logic wr_r;                         // Direction of the request
  logic [23:0] wdata_r;               // Word to write
  logic pack_r;                       // This access runs as three bytes
  logic pack_nxt;
  logic [1:0] beat_r;                 // Current byte beat
  logic [1:0] beat_nxt;
  logic [23:0] rdata_r;               // Assembled read word
  logic [23:0] rdata_nxt;
  logic [23:0] ext_addr_r;            // Address on the external bus
  logic [23:0] ext_wdata_r;           // Data on the external bus
  logic [3:0] strobe_r;               // Registered strobe pins

  // Decode view
  xaa_match_if mif ();

  wire logic take_w;                  // Request taken this cycle
  wire logic last_w;                  // Current beat is the last one
  wire logic beat_end_w;              // External cycle finishes now
  wire logic [1:0] last_idx_w;        // Index of the last beat
  wire logic [23:0] addr_nxt_w;       // Address of the coming cycle
  wire logic [23:0] wdata_nxt_w;      // Bus data of the coming cycle
  wire logic pack_hit_w;              // Matching register asks for packing
  wire logic [3:0] pack_en_w;         // Pack enable per register
  xaa_pkg::xaa_space_t space_nxt_w;   // Space of the coming cycle
  wire logic internal_nxt_w;          // Internal flag of the coming cycle

  // ---------------------------------------------------------------------------
  // Sequencing decode
  // ---------------------------------------------------------------------------
  // Requests while busy are ignored; the busy flag tells the source to wait
  assign take_w = (state_r == xaa_pkg::ST_IDLE) & i_acc_req;
  assign last_idx_w = pack_r ? xaa_pkg::LAST_PACKED : xaa_pkg::LAST_WORD;
  assign last_w = beat_r == last_idx_w;
  assign beat_end_w = (state_r == xaa_pkg::ST_BUS) & i_ext_done;

  for (genvar k = 0; k < 4; k++) begin : g_pack
    assign pack_en_w[k] = sel_r[k][xaa_pkg::PACK_BIT];
  end
  // Core accesses never pack, whatever the register says
  assign pack_hit_w = i_acc_dma & |(mif.hit & pack_en_w);

  // Next address: base plus beat; full address goes out, never multiplexed
  assign addr_nxt_w = take_w ? i_acc_addr
                             : 24'(base_r + {22'h000000, beat_nxt});
  assign space_nxt_w = take_w ? xaa_pkg::xaa_space_t'(i_acc_space) : space_r;
  assign internal_nxt_w = take_w ? i_acc_internal : internal_r;
  // Packed writes put one byte on the low lanes
  assign wdata_nxt_w = take_w ? (pack_nxt ? {16'h0000, get_byte(i_acc_wdata, 2'h0)}
                                          : i_acc_wdata)
                     : (pack_r ? {16'h0000, get_byte(wdata_r, beat_nxt)} : wdata_r);

  // Next state and beat
  always_comb begin
    state_nxt = state_r;
    beat_nxt = beat_r;
    pack_nxt = pack_r;
    rdata_nxt = rdata_r;
    case (state_r)
      xaa_pkg::ST_IDLE: begin
        // Capture and decide packing from the base address match
        if (i_acc_req) begin
          state_nxt = xaa_pkg::ST_BUS;
          beat_nxt = 2'h0;
          pack_nxt = pack_hit_w;
          rdata_nxt = 24'h000000;
        end
      end
      xaa_pkg::ST_BUS: begin
        // One beat per external done; low byte arrives first
        if (i_ext_done) begin
          rdata_nxt = pack_r ? put_byte(rdata_r, beat_r, i_ext_rdata[7:0])
                             : i_ext_rdata;
          if (last_w) begin
            state_nxt = xaa_pkg::ST_DONE;
          end else begin
            beat_nxt = 2'(beat_r + 2'h1);
          end
        end
      end
      xaa_pkg::ST_DONE: begin
        // Word complete; release the bus
        state_nxt = xaa_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = xaa_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Strobe decoder
  // ---------------------------------------------------------------------------
  // Decoder sees the coming cycle so the pins change with the address
  assign mif.addr = addr_nxt_w;
  assign mif.space = space_nxt_w;
  assign mif.internal = internal_nxt_w;
  assign mif.active = state_nxt == xaa_pkg::ST_BUS;
  assign mif.cfg = sel_r;

  xaa_strobe_decode u_decode (
    .mif(mif.dec)
  );

  // ---------------------------------------------------------------------------
  // Sequencer registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= xaa_pkg::ST_IDLE;
      beat_r <= 2'h0;
      pack_r <= 1'b0;
      rdata_r <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      beat_r <= beat_nxt;
      pack_r <= pack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Request capture; held for the whole word
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      base_r <= 24'h000000;
      space_r <= xaa_pkg::SP_PROG;
      internal_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 24'h000000;
    end else if (take_w) begin
      base_r <= i_acc_addr;
      space_r <= xaa_pkg::xaa_space_t'(i_acc_space);
      internal_r <= i_acc_internal;
      wr_r <= i_acc_wr;
      wdata_r <= i_acc_wdata;
    end
  end

  // External address, data and strobes move together each beat
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ext_addr_r <= 24'h000000;
      ext_wdata_r <= 24'h000000;
      strobe_r <= xaa_pkg::STROBE_IDLE;
    end else begin
      // Pins always follow the live decode, idle level included
      strobe_r <= mif.pin_lvl;
      if (take_w || (beat_end_w && !last_w)) begin
        ext_addr_r <= addr_nxt_w;
        ext_wdata_r <= wdata_nxt_w;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_acc_busy = state_r != xaa_pkg::ST_IDLE;
  assign o_acc_done = state_r == xaa_pkg::ST_DONE;
  assign o_acc_rdata = rdata_r;
  assign o_ext_cyc = state_r == xaa_pkg::ST_BUS;
  assign o_ext_wr = wr_r & (state_r == xaa_pkg::ST_BUS);
  assign o_ext_byte_mode = pack_r & (state_r == xaa_pkg::ST_BUS);
  assign o_ext_addr = ext_addr_r;
  assign o_ext_wdata = ext_wdata_r;
  // Held over all beats of a word, so nothing can take the bus between bytes
  assign o_bus_hold = state_r == xaa_pkg::ST_BUS;
  assign o_attr_strobe = strobe_r;

endmodule : xaa_attr_decode

`default_nettype wire

// ==== xaa_attr_decode_checker.sv ====
// Port-level assertions for the attribute decode.
// Assumes one core clock domain; bound into every xaa_attr_decode instance.
`timescale 1ns/1ps
`default_nettype none

module xaa_attr_decode_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Access request side
  input wire logic i_acc_req,
  input wire logic [23:0] i_acc_addr,
  input wire logic i_acc_dma,
  input wire logic o_acc_busy,
  input wire logic o_acc_done,
  // External bus side
  input wire logic o_ext_cyc,
  input wire logic o_ext_wr,
  input wire logic o_ext_byte_mode,
  input wire logic [23:0] o_ext_addr,
  input wire logic [23:0] o_ext_wdata,
  input wire logic i_ext_done,
  input wire logic o_bus_hold,
  input wire logic [3:0] o_attr_strobe
);
  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  logic take; // Request accepted this cycle
  logic [1:0] beat_r; // Beats finished in the current access
  logic [23:0] take_addr_r; // Address that came with the request
  assign take = i_acc_req && !o_acc_busy;

  // Beat count restarts with each access
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      beat_r <= 2'h0;
      take_addr_r <= 24'h000000;
    end else begin
      beat_r <= !o_ext_cyc ? 2'h0 : (i_ext_done ? beat_r + 2'h1 : beat_r);
      take_addr_r <= take ? i_acc_addr : take_addr_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_hold_tracks_cyc: assert property (o_bus_hold == o_ext_cyc)
    else $error("bus hold differs from cycle");
  a_take_starts_cyc: assert property (take |=> o_ext_cyc && o_ext_addr == take_addr_r)
    else $error("first beat wrong");
  a_core_no_pack: assert property (take && !i_acc_dma |=> !o_ext_byte_mode)
    else $error("core access packed");
  a_pack_next_byte: assert property (o_ext_cyc && o_ext_byte_mode && i_ext_done && beat_r != 2'h2
    |=> o_bus_hold && o_ext_addr == $past(o_ext_addr) + 24'h000001)
    else $error("packed address not stepped");
  a_pack_last_done: assert property (o_ext_cyc && o_ext_byte_mode && i_ext_done && beat_r == 2'h2
    |=> !o_ext_cyc && o_acc_done)
    else $error("packed access overran");
  a_word_one_beat: assert property (o_ext_cyc && !o_ext_byte_mode && i_ext_done
    |=> !o_ext_cyc && o_acc_done)
    else $error("word access overran");
  a_byte_low_lane: assert property (o_ext_cyc && o_ext_byte_mode && o_ext_wr
    |-> o_ext_wdata[23:8] == 16'h0000)
    else $error("packed data off low lane");
  a_beat_holds: assert property (o_ext_cyc && !i_ext_done
    |=> $stable(o_ext_addr) && $stable(o_attr_strobe))
    else $error("beat moved before done");
  a_done_single: assert property (o_acc_done |=> !o_acc_done && !o_acc_busy)
    else $error("done too long");

  c_packed: cover property (o_ext_cyc && o_ext_byte_mode && i_ext_done && beat_r == 2'h2);
  c_word: cover property (o_ext_cyc && !o_ext_byte_mode && i_ext_done);
  c_take: cover property (take && i_acc_dma);
endmodule : xaa_attr_decode_checker

bind xaa_attr_decode xaa_attr_decode_checker u_chk (.*);

`default_nettype wire

// ==== xaa_attr_decode_tb_top.sv ====
// Self-checking bench for the attribute decode.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none

module xaa_attr_decode_tb_top;
  typedef struct packed {
    logic [23:0] a; // Access address
    logic [1:0] sp; // Space code
    logic dma, wr, im; // DMA, write, internal map
    logic [23:0] wd; // Write data, or expected read word
  } xaa_row_t;
  logic i_core_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_acc_req, i_acc_dma, i_acc_wr;
  logic i_acc_internal, o_acc_busy, o_acc_done, o_ext_cyc, o_ext_wr, o_ext_byte_mode;
  logic i_ext_done, o_bus_hold;
  logic [23:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_acc_addr, i_acc_wdata, o_acc_rdata;
  logic [23:0] o_ext_addr, o_ext_wdata, i_ext_rdata;
  logic [1:0] i_acc_space;
  logic [3:0] o_attr_strobe, ext_wait;
  logic [23:0] cfg [4]; // Programmed values; no reserved counts, bit 6 zero
  int mismatches, checks_done, cycles;
  // Row addresses step so that +1 and +2 stay in one bank
  xaa_row_t rows [12] = '{
    '{24'h800010,2'h2,1'b1,1'b1,1'b0,24'h332211}, '{24'h800010,2'h2,1'b1,1'b0,1'b0,24'h332211},
    '{24'h800010,2'h2,1'b0,1'b0,1'b0,24'h000011}, '{24'h800011,2'h2,1'b0,1'b0,1'b0,24'h000022},
    '{24'h800012,2'h2,1'b0,1'b0,1'b0,24'h000033}, '{24'h4c0020,2'h1,1'b1,1'b1,1'b0,24'habcdef},
    '{24'h4c0020,2'h0,1'b1,1'b0,1'b0,24'habcdef}, '{24'h4c1020,2'h1,1'b0,1'b0,1'b0,24'habcdef},
    '{24'h600030,2'h0,1'b0,1'b1,1'b1,24'h0000aa}, '{24'h7ff030,2'h0,1'b1,1'b0,1'b0,24'h0000aa},
    '{24'h800040,2'h1,1'b1,1'b1,1'b0,24'h123456}, '{24'h800040,2'h2,1'b0,1'b0,1'b0,24'h123456}};

  xaa_attr_decode dut (.*);
  xaa_ext_mem_model u_mem (.i_clk(i_core_clk), .i_rst(i_sys_rst), .i_cyc(o_ext_cyc),
    .i_wr(o_ext_wr), .i_addr(o_ext_addr), .i_wdata(o_ext_wdata), .i_wait(ext_wait),
    .o_rdata(i_ext_rdata), .o_done(i_ext_done));

  // ---------------------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ---------------------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // Ceiling far above the run's length
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic reg_wr(input logic [23:0] a, input logic [23:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  // Read data stands one cycle
  task automatic reg_rd(input logic [23:0] a, input logic [23:0] exp);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 cmp(o_reg_rdata, exp);
  endtask : reg_rd
  // Expected {pack, strobes}; pin shows bit 2 when active
  function automatic logic [4:0] expect_of(input xaa_row_t r);
    logic [4:0] e;
    logic [3:0] c;
    logic [11:0] m;
    logic act;
    e = 5'h00;
    for (int n = 0; n < 4; n++) begin
      c = cfg[n][11:8];
      m = (c >= 4'hc) ? 12'hfff : ~(12'hfff >> c);
      act = cfg[n][r.sp == 2'h0 ? 3 : (r.sp == 2'h1 ? 4 : 5)];
      act = act && (((cfg[n][23:12] ^ r.a[23:12]) & m) == 12'h000) && !(c == 4'h0 && r.im);
      e[n] = act ~^ cfg[n][2];
      e[4] = e[4] | (act && cfg[n][7] && r.dma);
    end
    return e;
  endfunction : expect_of
  task automatic acc(input xaa_row_t r, input logic [3:0] w);
    logic [4:0] e;
    int n, beats;
    e = expect_of(r);
    @(posedge i_core_clk);
    {i_acc_req, i_acc_addr, i_acc_space, i_acc_dma, i_acc_wr} <= {1'b1, r.a, r.sp, r.dma, r.wr};
    {i_acc_internal, i_acc_wdata, ext_wait} <= {r.im, r.wd, w};
    @(posedge i_core_clk);
    i_acc_req <= 1'b0;
    #1 cmp(o_attr_strobe, e[3:0]);
    cmp(o_ext_byte_mode, e[4]);
    n = 0;
    beats = 0;
    while (o_acc_done !== 1'b1 && n < 200) begin
      if (o_ext_cyc === 1'b1 && i_ext_done === 1'b1) beats++;
      @(posedge i_core_clk);
      #1 n++;
    end
    cmp(24'(beats), e[4] ? 24'h3 : 24'h1);
    if (!r.wr) cmp(o_acc_rdata, r.wd);
  endtask : acc

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {i_sys_rst, i_reg_wr, i_reg_rd, i_acc_req, i_acc_dma, i_acc_wr, i_acc_internal} = 7'h40;
    {i_reg_addr, i_reg_wdata, i_acc_addr, i_acc_wdata, i_acc_space, ext_wait} = '0;
    cfg = '{24'h8001a0, 24'h4c0c1c, 24'h000038, 24'h60030c};
    repeat (5) @(posedge i_core_clk);
    #1 cmp(o_attr_strobe, 4'hf);
    @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) reg_rd(xaa_pkg::OFS_SEL0 - 24'(k), 24'h000000);
    reg_rd(24'h0ffffa, 24'h000000);
    reg_wr(xaa_pkg::OFS_SEL3, 24'hffffff);
    reg_rd(xaa_pkg::OFS_SEL3, xaa_pkg::SEL_RW_MASK);
    for (int k = 0; k < 4; k++) reg_wr(xaa_pkg::OFS_SEL0 - 24'(k), cfg[k]);
    for (int k = 0; k < 4; k++) reg_rd(xaa_pkg::OFS_SEL0 - 24'(k), cfg[k]);
    #1 cmp(o_attr_strobe, 4'h5);
    // Odd rows get wait cycles
    for (int k = 0; k < 12; k++) acc(rows[k], k[0] ? 4'h3 : 4'h0);
    // Reset in mid packed access
    @(posedge i_core_clk);
    {i_acc_req, i_acc_addr, i_acc_space, i_acc_dma, i_acc_wr} <= {1'b1, 24'h800010, 2'h2, 2'h2};
    ext_wait <= 4'h3;
    @(posedge i_core_clk);
    i_acc_req <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_sys_rst <= 1'b1;
    @(posedge i_core_clk);
    #1 cmp(o_attr_strobe, 4'hf);
    cmp(o_ext_cyc, 1'b0);
    @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    reg_rd(xaa_pkg::OFS_SEL0, 24'h000000);
    complete_run();
  end
endmodule : xaa_attr_decode_tb_top

`default_nettype wire

// ==== xaa_ext_mem_model.sv ====
// Behavioural external memory behind the attribute decode.
// Assumes one beat at a time; the bench sets the answer delay per access.
`timescale 1ns/1ps
`default_nettype none

module xaa_ext_mem_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus cycle from the device
  input wire logic i_cyc,
  input wire logic i_wr,
  input wire logic [23:0] i_addr,
  input wire logic [23:0] i_wdata,
  // Pace set by the bench
  input wire logic [3:0] i_wait,
  // Answer to the device
  output logic [23:0] o_rdata,
  output logic o_done
);
  logic [23:0] mem_r [256]; // Low address byte picks a location
  logic [3:0] cnt_r; // Wait cycles spent in this beat

  // Answer after i_wait cycles; data toggles outside done
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 4'h0;
      o_done <= 1'b0;
      o_rdata <= 24'h5a5a5a;
    end else if (i_cyc && !o_done && cnt_r == i_wait) begin
      cnt_r <= 4'h0;
      o_done <= 1'b1;
      o_rdata <= mem_r[i_addr[7:0]];
      if (i_wr) mem_r[i_addr[7:0]] <= i_wdata; // Keeps the low-lane byte too
    end else begin
      cnt_r <= (i_cyc && !o_done) ? cnt_r + 4'h1 : cnt_r;
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule : xaa_ext_mem_model

`default_nettype wire

// ==== xaa_match_if.sv ====
// Carrier between the attribute controller and the strobe decoder.
// Assumes the controller drives the access view and the decoder answers combinationally.
`timescale 1ns/1ps
`default_nettype none

interface xaa_match_if;
  logic [23:0] addr;              // Address of the coming external cycle
  xaa_pkg::xaa_space_t space;     // Space of the coming cycle
  logic internal;                 // Address lies in the internal map
  logic active;                   // An external cycle is coming
  logic [23:0] cfg [4];           // Attribute select registers
  wire logic [3:0] hit;           // Per-register match
  wire logic [3:0] pin_lvl;       // Pin level after polarity

  modport ctrl (output addr, space, internal, active, cfg, input hit, pin_lvl);
  modport dec (input addr, space, internal, active, cfg, output hit, pin_lvl);
endinterface : xaa_match_if

`default_nettype wire

// ==== xaa_pkg.sv ====
// Constants, field layout and types for the external address attribute decode.
// Assumes a single core clock and that all users refer to names as xaa_pkg::name.
//
// Overview of operation
// - Strobe asserts on field match in enabled space
// - Compare field bits 23..12, top address bits
// - Count field picks top bits to compare
// - Count zero matches whole space outside internal
// - Packing: three byte accesses at base, +1, +2
// - Bytes on low lanes, little endian order
// - Packing off: one 24-bit access per word
// - Packing applies to DMA accesses only
// - Keep bus mastership across three bytes
// - No row/column address multiplexing
// - Bits 5/4/3 enable Y, X, program spaces
// - Bit 2 set gives active-high strobe

package xaa_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 24;  // External address width
  localparam int unsigned DATA_W = 24;  // Word and register width
  localparam int unsigned NUM_SEL = 4;  // Attribute select registers / strobe pins
  localparam int unsigned BYTE_W = 8;   // Byte-wide memory lane

  // ---------------------------------------------------------------------------
  // Register offsets, word addressed
  // ---------------------------------------------------------------------------
  localparam logic [23:0] OFS_SEL0 = 24'h0ffff9;
  localparam logic [23:0] OFS_SEL1 = 24'h0ffff8;
  localparam logic [23:0] OFS_SEL2 = 24'h0ffff7;
  localparam logic [23:0] OFS_SEL3 = 24'h0ffff6;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned CMP_ADDR_HI = 23;  // Compare address field
  localparam int unsigned CMP_ADDR_LO = 12;
  localparam int unsigned CMP_CNT_HI = 11;   // Compare count field
  localparam int unsigned CMP_CNT_LO = 8;
  localparam int unsigned PACK_BIT = 7;      // Byte pack enable
  localparam int unsigned Y_EN_BIT = 5;      // Y data space match enable
  localparam int unsigned X_EN_BIT = 4;      // X data space match enable
  localparam int unsigned P_EN_BIT = 3;      // Program space match enable
  localparam int unsigned POL_BIT = 2;       // Strobe polarity

  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [23:0] SEL_RESET = 24'h000000;    // All fields clear
  localparam logic [23:0] SEL_RW_MASK = 24'hffffbc;  // Bits 6, 1, 0 read zero
  localparam logic [3:0] CNT_WHOLE = 4'h0;           // Match whole space
  localparam logic [11:0] MASK_ALL = 12'hfff;        // Full compare mask
  localparam logic [3:0] STROBE_IDLE = 4'hf;         // Pins idle at reset polarity
  localparam logic [1:0] LAST_PACKED = 2'h2;         // Last beat index, packed
  localparam logic [1:0] LAST_WORD = 2'h0;           // Last beat index, word

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SP_PROG = 2'h0,
    SP_X = 2'h1,
    SP_Y = 2'h2
  } xaa_space_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUS = 3'h2,
    ST_DONE = 3'h4
  } xaa_state_t;

endpackage : xaa_pkg

// ==== xaa_strobe_decode.sv ====
// Strobe match decode for the four attribute select registers.
// Assumes the controller presents the address and space of the next cycle.
`timescale 1ns/1ps
`default_nettype none

module xaa_strobe_decode (
  // Match view
  xaa_match_if.dec mif
);

  // ---------------------------------------------------------------------------
  // Compare mask helper
  // ---------------------------------------------------------------------------
  // Top n bits set; reserved counts above twelve simply compare all twelve
  function automatic logic [11:0] cmp_mask(input logic [3:0] n);
    cmp_mask = ~(xaa_pkg::MASK_ALL >> n);
  endfunction : cmp_mask

  // ---------------------------------------------------------------------------
  // Per-register decode
  // ---------------------------------------------------------------------------
  genvar g;
  for (g = 0; g < xaa_pkg::NUM_SEL; g++) begin : g_sel
    wire logic [11:0] mask_w;   // Bits that take part in the compare
    wire logic space_en_w;      // Current space enabled here
    wire logic addr_eq_w;       // Masked top bits agree
    wire logic whole_w;         // Count of zero
    wire logic [3:0] cnt_w;     // Compare count field
    assign cnt_w = mif.cfg[g][xaa_pkg::CMP_CNT_HI:xaa_pkg::CMP_CNT_LO];
    assign mask_w = cmp_mask(cnt_w);
    // Always the most significant address bits, 23..12
    assign addr_eq_w = ((mif.addr[23:12]
      ^ mif.cfg[g][xaa_pkg::CMP_ADDR_HI:xaa_pkg::CMP_ADDR_LO]) & mask_w) == 12'h000;
    assign space_en_w = ((mif.space == xaa_pkg::SP_Y) & mif.cfg[g][xaa_pkg::Y_EN_BIT])
      | ((mif.space == xaa_pkg::SP_X) & mif.cfg[g][xaa_pkg::X_EN_BIT])
      | ((mif.space == xaa_pkg::SP_PROG) & mif.cfg[g][xaa_pkg::P_EN_BIT]);
    assign whole_w = cnt_w == xaa_pkg::CNT_WHOLE;
    // Whole-space match only for addresses outside the internal map
    assign mif.hit[g] = mif.active & space_en_w & addr_eq_w
      & (~whole_w | ~mif.internal);
    // Clear polarity bit gives an active-low pin
    assign mif.pin_lvl[g] = ~(mif.hit[g] ^ mif.cfg[g][xaa_pkg::POL_BIT]);
  end

endmodule : xaa_strobe_decode

`default_nettype wire
